/* File: src/usrc_top.sv */
// Serial port receive-control block with its register set.
// Assumes an AHB-Lite master, single word transfers, one clock.
`timescale 1ns/10ps
`default_nettype none
module usrc_top (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        resetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial pins, output enables active low.
    input  wire logic        rx_data_in,
    output logic             rx_data_out,
    output logic             rx_data_oe_n,
    input  wire logic        tx_clock_in,
    output logic             tx_clock_out,
    output logic             tx_clock_oe_n,
    // Interrupt and pin ownership.
    output logic             irq,
    output logic             serial_owns_pins
);
    import usrc_pkg::*;
    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} usrc_rx_t;
    typedef struct packed {
        logic [2:0]  rx_sync;
        logic [2:0]  ck_sync;
        logic [7:0]  rcs;
        logic [7:0]  txs;
        logic [7:0]  baud;
        logic [7:0]  peripheral_irq_enables;
        logic        txif;
        logic        bank;
        logic [7:0]  rxbuf;
        logic        rxbuf9;
        logic        full;
        logic [7:0]  shift;
        logic        shift9;
        logic [3:0]  bitn;
        logic [3:0]  pre;
        usrc_rx_t    st;
        logic        ap_valid;
        logic        ap_write;
        logic [11:0] ap_addr;
        logic [31:0] rdata;
        logic        ck_out;
        logic        irq;
        logic        own;
    } usrc_st_t;
    usrc_st_t s_r, s_nxt;
    logic        tick;
    logic        baud_restart;
    logic        sync_mode;
    logic        rx_pin;
    logic        ck_pin;
    logic        ck_rise;
    logic        rx_active;
    logic [7:0]  pir_view;
    logic [7:0]  rcs_view;
    logic        word_done;
    logic        bit_strobe;
    logic [3:0]  nbits;
    logic [11:0] ad;
    logic        rd_rcs;
    logic        rd_buf;
    // =========================================================
    // Baud timer.
    usrc_baud #(.W(8)) u_baud (
        .clk     (clk),
        .resetn  (resetn),
        .divisor (s_r.baud),
        .restart (baud_restart),
        .tick    (tick)
    );
    // =========================================================
    // Receive engine and register file.
    always_comb
    begin
        s_nxt = s_r;
        sync_mode = s_r.txs[TXS_SYNC];
        rx_pin = s_r.rx_sync[1];
        ck_pin = s_r.ck_sync[1];
        ck_rise = s_r.ck_sync[1] & ~s_r.ck_sync[2];
        // Continuous wins over single; single counts only in sync mode.
        rx_active = s_r.rcs[RCS_SERIAL_PORT_ENABLE] & (s_r.rcs[RCS_CONTINUOUS_RECEIVE_ENABLE] |
                    (sync_mode & s_r.rcs[RCS_SINGLE_RECEIVE_ENABLE]));
        nbits = s_r.rcs[RCS_NINE] ? 4'd9 : 4'd8;
        word_done = 1'b0;
        baud_restart = 1'b0;
        s_nxt.rx_sync = {s_r.rx_sync[1:0], rx_data_in};
        s_nxt.ck_sync = {s_r.ck_sync[1:0], tx_clock_in};
        // The master clock runs only while a word is clocked in, then
        // settles low so the line stands still between words.
        if (sync_mode && tick && (s_r.st == RX_DATA || s_r.ck_out))
            s_nxt.ck_out = ~s_r.ck_out;
        // Master samples on its own rising clock, slave on the pin's.
        if (s_r.txs[TXS_CSRC])
            bit_strobe = tick & ~s_r.ck_out;
        else
            bit_strobe = ck_rise;
        // Async: 16 ticks of 4(x+1) cycles give fosc/64(x+1).
        if (!sync_mode && tick)
            s_nxt.pre = s_r.pre + 4'd1;
        ad = s_r.ap_addr;
        rd_rcs = 1'b0;
        rd_buf = 1'b0;
        unique case (s_r.st)
            RX_IDLE:
            begin
                s_nxt.bitn = 4'd0;
                s_nxt.shift9 = 1'b0;
                if (rx_active && sync_mode)
                    s_nxt.st = RX_DATA;
                else if (rx_active && tick && !rx_pin)
                begin
                    s_nxt.st = RX_DATA;
                    s_nxt.pre = 4'd8;
                end
            end
            RX_DATA:
            begin
                if (!rx_active)
                    s_nxt.st = RX_IDLE;
                else if ((sync_mode && bit_strobe) ||
                         (!sync_mode && tick && s_r.pre == 4'd15))
                begin
                    // The ninth bit follows the eight data bits.
                    if (s_r.rcs[RCS_NINE] &&
                        s_r.bitn == (sync_mode ? 4'd8 : 4'd9))
                        s_nxt.shift9 = rx_pin;
                    else
                        s_nxt.shift = {rx_pin, s_r.shift[7:1]};
                    if (!sync_mode && s_r.bitn == 4'd0 && !s_r.rx_sync[2])
                        s_nxt.bitn = 4'd0;
                    s_nxt.bitn = s_r.bitn + 4'd1;
                    if (s_r.bitn == (sync_mode ? nbits - 4'd1 : nbits))
                    begin
                        s_nxt.st = sync_mode ? RX_IDLE : RX_STOP;
                        word_done = sync_mode;
                    end
                end
            end
            RX_STOP:
            begin
                if (tick && s_r.pre == 4'd15)
                begin
                    s_nxt.st = RX_IDLE;
                    word_done = 1'b1;
                    s_nxt.rcs[RCS_FRAMING_ERROR_FLAG] = ~rx_pin;
                end
            end
        endcase
        // Async shift takes the start bit first; the eighth data bit shifts it out.
        if (word_done)
        begin
            if (s_r.full)
                s_nxt.rcs[RCS_OVERRUN_ERROR_FLAG] = 1'b1;
            else
            begin
                s_nxt.full = 1'b1;
                s_nxt.rxbuf = s_nxt.shift;
                s_nxt.rxbuf9 = s_nxt.shift9;
                s_nxt.rcs[RCS_RX9] = s_nxt.shift9;
            end
            if (sync_mode && !s_r.rcs[RCS_CONTINUOUS_RECEIVE_ENABLE])
                s_nxt.rcs[RCS_SINGLE_RECEIVE_ENABLE] = 1'b0;
        end
        s_nxt.txif = 1'b1;
        pir_view = 8'h00;
        pir_view[PIR_RXIF] = s_r.full;
        pir_view[PIR_TXIF] = s_r.txif;
        rcs_view = s_r.rcs & 8'hf7;
        // AHB address phase capture.
        s_nxt.ap_valid = hsel & hready & (htrans == HTRANS_NONSEQ ||
                         htrans == HTRANS_SEQ);
        if (hready)
        begin
            s_nxt.ap_write = hwrite;
            s_nxt.ap_addr = {haddr[11:2], 2'b00};
        end
        if (s_r.bank)
            ad = s_r.ap_addr + BANK1_OFFSET;
        // Reads complete the cycle after the address phase.
        s_nxt.rdata = 32'h0000_0000;
        if (s_nxt.ap_valid && !hwrite)
        begin
            ad = {haddr[11:2], 2'b00} + (s_r.bank ? BANK1_OFFSET : 12'h000);
            if (ad == {2'b00, IDX_RX_STAT_CTRL, 2'b00})
            begin
                s_nxt.rdata[7:0] = rcs_view;
                rd_rcs = 1'b1;
            end
            else if (ad == {2'b00, IDX_RX_BUFFER, 2'b00})
            begin
                s_nxt.rdata[7:0] = s_r.rxbuf;
                rd_buf = 1'b1;
            end
            else if (ad == {2'b00, IDX_TX_STAT_CTRL, 2'b00})
                s_nxt.rdata[7:0] = s_r.txs;
            else if (ad == {2'b00, IDX_BAUD_DIVISOR, 2'b00})
                s_nxt.rdata[7:0] = s_r.baud;
            else if (ad == {2'b00, IDX_BANK_SELECT, 2'b00})
                s_nxt.rdata[7:0] = {7'd0, s_r.bank};
            else if (ad == BANK1_OFFSET + {2'b00, IDX_PIR_FLAGS, 2'b00})
                s_nxt.rdata[7:0] = pir_view;
            else if (ad == BANK1_OFFSET + {2'b00, IDX_PIE_ENABLES, 2'b00})
                s_nxt.rdata[7:0] = s_r.peripheral_irq_enables;
        end
        // Buffer read frees it unless a word completes in the same cycle.
        if (rd_buf && !word_done)
            s_nxt.full = 1'b0;
        // Data phase writes.
        if (s_r.ap_valid && s_r.ap_write)
        begin
            ad = s_r.ap_addr + (s_r.bank ? BANK1_OFFSET : 12'h000);
            if (ad == {2'b00, IDX_RX_STAT_CTRL, 2'b00})
            begin
                s_nxt.rcs[7:4] = hwdata[7:4];
                if (!hwdata[RCS_CONTINUOUS_RECEIVE_ENABLE])
                    s_nxt.rcs[RCS_OVERRUN_ERROR_FLAG] = 1'b0;
                if (word_done && sync_mode && !s_r.rcs[RCS_CONTINUOUS_RECEIVE_ENABLE])
                    s_nxt.rcs[RCS_SINGLE_RECEIVE_ENABLE] = 1'b0;
            end
            else if (ad == {2'b00, IDX_TX_STAT_CTRL, 2'b00})
                s_nxt.txs = {hwdata[7:4], 2'b00, s_r.txs[TXS_TRMT],
                             hwdata[0]};
            else if (ad == {2'b00, IDX_BAUD_DIVISOR, 2'b00})
            begin
                s_nxt.baud = hwdata[7:0];
                baud_restart = 1'b1;
            end
            else if (ad == {2'b00, IDX_BANK_SELECT, 2'b00})
                s_nxt.bank = hwdata[0];
            else if (ad == BANK1_OFFSET + {2'b00, IDX_PIE_ENABLES, 2'b00})
                s_nxt.peripheral_irq_enables = hwdata[7:0];
        end
        s_nxt.own = s_nxt.rcs[RCS_SERIAL_PORT_ENABLE];
        s_nxt.irq = |({s_nxt.txif, s_nxt.full} & s_nxt.peripheral_irq_enables[1:0]);
        if (rd_rcs)
            s_nxt.rdata[31:8] = 24'h000000;
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= '0;
            s_r.rcs <= RCS_RESET;
            s_r.txs <= TXS_RESET;
            s_r.baud <= BAUD_RESET;
            s_r.peripheral_irq_enables <= PIE_RESET;
            s_r.st <= RX_IDLE;
        end
        else
            s_r <= s_nxt;
    end
    // =========================================================
    // Outputs from flip-flops or tie-offs; tx_clock_oe_n is gated from flip-flops.
    assign hrdata = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = s_r.irq;
    assign serial_owns_pins = s_r.own;
    assign rx_data_out = 1'b0;
    assign rx_data_oe_n = 1'b1;
    assign tx_clock_out = s_r.ck_out;
    assign tx_clock_oe_n = ~(s_r.own & s_r.txs[TXS_SYNC] & s_r.txs[TXS_CSRC]);
    // =========================================================
    // Checks.
    AST_OWN: assert property (@(posedge clk) disable iff (!resetn)
        s_r.own == s_r.rcs[RCS_SERIAL_PORT_ENABLE]) else $error("pin ownership wrong");
    AST_UNUSED: assert property (@(posedge clk) disable iff (!resetn)
        rd_rcs |=> hrdata[3] == 1'b0) else $error("unused bit read one");
    AST_ASYNC_SINGLE_RECEIVE_ENABLE: assert property (@(posedge clk) disable iff (!resetn)
        (!s_r.txs[TXS_SYNC] && !s_r.rcs[RCS_CONTINUOUS_RECEIVE_ENABLE] && s_r.st == RX_IDLE)
        |=> s_r.st == RX_IDLE) else $error("async single enable acted");
    AST_OVERRUN_ERROR_FLAG: assert property (@(posedge clk) disable iff (!resetn)
        (word_done && s_r.full) |=> s_r.rcs[RCS_OVERRUN_ERROR_FLAG])
        else $error("overrun not flagged");
    AST_SINGLE_RECEIVE_ENABLE_CLR: assert property (@(posedge clk) disable iff (!resetn)
        (word_done && s_r.txs[TXS_SYNC] && !s_r.rcs[RCS_CONTINUOUS_RECEIVE_ENABLE])
        |=> !s_r.rcs[RCS_SINGLE_RECEIVE_ENABLE]) else $error("single enable not cleared");
    AST_CONTINUOUS_RECEIVE_ENABLE_KEEP: assert property (@(posedge clk) disable iff (!resetn)
        (word_done && s_r.rcs[RCS_CONTINUOUS_RECEIVE_ENABLE] && !(s_r.ap_valid && s_r.ap_write))
        |=> s_r.rcs[RCS_CONTINUOUS_RECEIVE_ENABLE]) else $error("continuous enable dropped");
    AST_IRQ: assert property (@(posedge clk) disable iff (!resetn)
        (s_r.full && s_r.peripheral_irq_enables[PIR_RXIF]) |-> ##[0:1] irq)
        else $error("receive interrupt missing");
    AST_FULL: assert property (@(posedge clk) disable iff (!resetn)
        (word_done && !s_r.full) |=> s_r.full) else $error("flag not set");
endmodule : usrc_top
`default_nettype wire

/* File: include/usrc_pkg.sv */
// Package for the serial port receive-control register block.
// Assumes an AHB-Lite slave with 32-bit data, one word per register.
package usrc_pkg;
    // ==========================================================
    // Register indices (file addresses) and bus byte addresses.
    localparam logic [7:0]  IDX_CORE_STATUS   = 8'h06;
    localparam logic [7:0]  IDX_INT_STATUS    = 8'h07;
    localparam logic [7:0]  IDX_RX_STAT_CTRL  = 8'h13;
    localparam logic [7:0]  IDX_RX_BUFFER     = 8'h14;
    localparam logic [7:0]  IDX_TX_STAT_CTRL  = 8'h15;
    localparam logic [7:0]  IDX_TX_BUFFER     = 8'h16;
    localparam logic [7:0]  IDX_BAUD_DIVISOR  = 8'h17;
    localparam logic [7:0]  IDX_PIR_FLAGS     = 8'h16;
    localparam logic [7:0]  IDX_PIE_ENABLES   = 8'h17;
    localparam logic [7:0]  IDX_BANK_SELECT   = 8'h0f;
    // Bank 1 registers sit at byte address + bank offset.
    localparam logic [11:0] BANK1_OFFSET      = 12'h100;
    // ==========================================================
    // Receive status/control field positions.
    localparam int RCS_SERIAL_PORT_ENABLE  = 7;
    localparam int RCS_NINE  = 6;
    localparam int RCS_SINGLE_RECEIVE_ENABLE  = 5;
    localparam int RCS_CONTINUOUS_RECEIVE_ENABLE  = 4;
    localparam int RCS_FRAMING_ERROR_FLAG  = 2;
    localparam int RCS_OVERRUN_ERROR_FLAG  = 1;
    localparam int RCS_RX9   = 0;
    // Transmit status/control fields used here.
    localparam int TXS_SYNC  = 4;
    localparam int TXS_CSRC  = 7;
    localparam int TXS_TRMT  = 1;
    // Peripheral flag / enable positions.
    localparam int PIR_RXIF  = 0;
    localparam int PIR_TXIF  = 1;
    // Reset values.
    localparam logic [7:0] RCS_RESET   = 8'h00;
    localparam logic [7:0] TXS_RESET   = 8'h02;
    localparam logic [7:0] PIE_RESET   = 8'h00;
    localparam logic [7:0] BAUD_RESET  = 8'h00;
    // Asynchronous mode: 16 baud ticks per bit, sync master: 2 ticks per bit (one clock period).
    localparam int ASYNC_PRE  = 16;
    localparam int SYNC_PRE   = 1;
    // AHB constants.
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ    = 2'b11;
endpackage : usrc_pkg

/* File: src/usrc_baud.sv */
// Free-running baud timer producing one-cycle tick pulses.
// Assumes a single clock; divisor writes restart the timer.
`timescale 1ns/10ps
`default_nettype none
module usrc_baud #(
    parameter int W = 8
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         resetn,
    // Control.
    input  wire logic [W-1:0] divisor,
    input  wire logic         restart,
    // Four-clock quarter tick (core cycle) gated tick output.
    output logic              tick
);
    typedef struct packed {
        logic [1:0]   quarter;
        logic [W-1:0] cnt;
        logic         tick;
    } usrc_baud_st_t;
    usrc_baud_st_t s_r, s_nxt;
    // =========================================================
    // Timer: period of 4*(x+1) oscillator cycles per tick.
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (restart)
        begin
            s_nxt.quarter = 2'd0;
            s_nxt.cnt = '0;
        end
        else
        begin
            s_nxt.quarter = s_r.quarter + 2'd1;
            if (s_r.quarter == 2'd3)
            begin
                if (s_r.cnt == divisor)
                begin
                    s_nxt.cnt = '0;
                    s_nxt.tick = 1'b1;
                end
                else
                    s_nxt.cnt = s_r.cnt + 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
    assign tick = s_r.tick;
endmodule : usrc_baud
`default_nettype wire

/* File: test/usrc_peer.sv */
// Behavioural serial peer driving the receive data pin of the block.
// Assumes the bench calls send_frame right after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module usrc_peer (
    // Clock.
    input  wire logic clk,
    // Serial line towards the block.
    output logic      line
);
    logic drv;

    initial
    begin
        drv = 1'b1;
    end

    // The line idles at the mark level between frames and in synchronous
    // mode, so a synchronous word received from it is all ones.
    assign line = drv;

    // ==========================================================
    // Asynchronous frame: start bit, eight data bits LSB first, stop bit.
    task automatic send_frame(input logic [7:0] data, input logic stop_bit,
                              input int bit_cycles);
        logic [9:0] frame;
        int         i;
        frame = {stop_bit, data, 1'b0};
        for (i = 0; i < 10; i++)
        begin
            drv <= frame[i];
            repeat (bit_cycles) @(posedge clk);
        end
        drv <= 1'b1;
        @(posedge clk);
    endtask : send_frame
endmodule : usrc_peer
`default_nettype wire

/* File: test/usart_receive_control_regs_tb.sv */
// Self-checking bench for the serial port receive-control register block.
// Assumes usrc_pkg, usrc_top and usrc_peer are compiled beforehand.
`timescale 1ns/10ps
`default_nettype none
module usart_receive_control_regs_tb;
    import usrc_pkg::*;
    localparam int DIV = 1;
    localparam int BIT = 64 * (DIV + 1);

    logic        clk;
    logic        resetn;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        rx_data_in;
    logic        tx_clock_in;
    logic        tx_clock_out;
    logic        tx_clock_oe_n;
    logic        irq;
    logic        serial_owns_pins;
    logic [31:0] r;
    int          num_errors;
    int          checked;
    int          cnt;
    logic        prev;

    usrc_top dut (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rx_data_in(rx_data_in), .rx_data_out(),
        .rx_data_oe_n(), .tx_clock_in(tx_clock_in),
        .tx_clock_out(tx_clock_out), .tx_clock_oe_n(tx_clock_oe_n),
        .irq(irq), .serial_owns_pins(serial_owns_pins)
    );

    usrc_peer peer (
        .clk(clk),
        .line(rx_data_in)
    );

    always #5 clk = ~clk;

    // ==========================================================
    // Reporting.
    task automatic wrap_up();
        if (num_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask : chk

    // ==========================================================
    // Bus access: address phase, then data phase, each held until hready.
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100)
        begin
            $display("mismatch hready expected 1 seen %b", hreadyout);
            num_errors++;
            wrap_up();
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'b010;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask : wr

    task automatic rchk(input string n, input logic [11:0] a,
                        input logic [31:0] e);
        logic [31:0] g;
        bus(1'b0, a, 32'h0, g);
        chk(n, e, g);
    endtask : rchk

    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        while (irq !== e && n < 4000)
        begin
            @(posedge clk);
            n++;
        end
        chk("irq", {31'h0, e}, {31'h0, irq});
        if (n >= 4000)
            wrap_up();
    endtask : wait_irq

    function automatic logic [11:0] fa(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : fa

    // ==========================================================
    // Main sequence.
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        tx_clock_in = 1'b0;
        num_errors = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rchk("rcs", fa(IDX_RX_STAT_CTRL), {24'h0, RCS_RESET});
        rchk("txs", fa(IDX_TX_STAT_CTRL), {24'h0, TXS_RESET});
        rchk("pir", fa(IDX_PIR_FLAGS) + BANK1_OFFSET, 32'h2);
        rchk("pie", fa(IDX_PIE_ENABLES) + BANK1_OFFSET, 32'h0);
        rchk("unmapped", 12'h3fc, 32'h0);
        chk("owns", 32'h0, {31'h0, serial_owns_pins});
        wr(fa(IDX_RX_STAT_CTRL), 32'hff);
        rchk("rcs", fa(IDX_RX_STAT_CTRL), 32'hf0);
        chk("owns", 32'h1, {31'h0, serial_owns_pins});
        wr(fa(IDX_BAUD_DIVISOR), 32'(DIV));
        rchk("baud", fa(IDX_BAUD_DIVISOR), 32'(DIV));
        wr(fa(IDX_PIE_ENABLES) + BANK1_OFFSET, 32'h1);
        // Single enable alone must not receive in asynchronous mode.
        wr(fa(IDX_RX_STAT_CTRL), 32'ha0);
        peer.send_frame(8'h3c, 1'b1, BIT);
        repeat (BIT) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        rchk("rcs", fa(IDX_RX_STAT_CTRL), 32'ha0);
        // Continuous reception at the programmed bit rate.
        wr(fa(IDX_RX_STAT_CTRL), 32'h90);
        peer.send_frame(8'ha5, 1'b1, BIT);
        wait_irq(1'b1);
        rchk("pir", fa(IDX_PIR_FLAGS) + BANK1_OFFSET, 32'h3);
        wr(fa(IDX_PIE_ENABLES) + BANK1_OFFSET, 32'h0);
        wait_irq(1'b0);
        wr(fa(IDX_PIE_ENABLES) + BANK1_OFFSET, 32'h1);
        wait_irq(1'b1);
        rchk("rcs", fa(IDX_RX_STAT_CTRL), 32'h90);
        rchk("rxbuf", fa(IDX_RX_BUFFER), 32'ha5);
        wait_irq(1'b0);
        // Three unread words overrun the buffer.
        peer.send_frame(8'h11, 1'b1, BIT);
        peer.send_frame(8'h22, 1'b1, BIT);
        peer.send_frame(8'h33, 1'b1, BIT);
        repeat (8) @(posedge clk);
        bus(1'b0, fa(IDX_RX_STAT_CTRL), 32'h0, r);
        chk("overrun_error_flag", 32'h1, {31'h0, r[RCS_OVERRUN_ERROR_FLAG]});
        bus(1'b0, fa(IDX_RX_BUFFER), 32'h0, r);
        bus(1'b0, fa(IDX_RX_STAT_CTRL), 32'h0, r);
        chk("overrun_error_flag", 32'h1, {31'h0, r[RCS_OVERRUN_ERROR_FLAG]});
        wr(fa(IDX_RX_STAT_CTRL), 32'h80);
        bus(1'b0, fa(IDX_RX_STAT_CTRL), 32'h0, r);
        chk("overrun_error_flag", 32'h0, {31'h0, r[RCS_OVERRUN_ERROR_FLAG]});
        repeat (3) bus(1'b0, fa(IDX_RX_BUFFER), 32'h0, r);
        wait_irq(1'b0);
        // A missing stop bit flags a framing error.
        wr(fa(IDX_RX_STAT_CTRL), 32'h90);
        peer.send_frame(8'h5a, 1'b0, BIT);
        wait_irq(1'b1);
        bus(1'b0, fa(IDX_RX_STAT_CTRL), 32'h0, r);
        chk("framing_error_flag", 32'h1, {31'h0, r[RCS_FRAMING_ERROR_FLAG]});
        rchk("rxbuf", fa(IDX_RX_BUFFER), 32'h5a);
        wait_irq(1'b0);
        // Synchronous master: one word on the single enable.
        wr(fa(IDX_RX_STAT_CTRL), 32'h80);
        wr(fa(IDX_TX_STAT_CTRL), 32'h90);
        wr(fa(IDX_RX_STAT_CTRL), 32'ha0);
        repeat (2) @(posedge clk);
        chk("ck_oe_n", 32'h0, {31'h0, tx_clock_oe_n});
        wait_irq(1'b1);
        bus(1'b0, fa(IDX_RX_STAT_CTRL), 32'h0, r);
        chk("single_receive_enable", 32'h0, {31'h0, r[RCS_SINGLE_RECEIVE_ENABLE]});
        rchk("rxbuf", fa(IDX_RX_BUFFER), 32'hff);
        // Continuous overrides single: the clock keeps running.
        wr(fa(IDX_RX_STAT_CTRL), 32'hb0);
        cnt = 0;
        prev = tx_clock_out;
        repeat (400)
        begin
            @(posedge clk);
            if (tx_clock_out === 1'b1 && prev === 1'b0)
                cnt++;
            prev = tx_clock_out;
        end
        chk("clk_run", 32'h1, {31'h0, cnt >= 20});
        bus(1'b0, fa(IDX_RX_STAT_CTRL), 32'h0, r);
        chk("continuous_receive_enable", 32'h1, {31'h0, r[RCS_CONTINUOUS_RECEIVE_ENABLE]});
        wrap_up();
    end
endmodule : usart_receive_control_regs_tb
`default_nettype wire
